// file: verilog/csid_lamp_driver.sv
// Purpose: Drive coupler front-panel status lamps from internal state
// Assumes: Status inputs synchronous to ref_clk_i, lamp outputs active high
// Notes: Error indications take priority over normal ones on system and health lamps (bar hot swap flash with substitution), not on link
// Contract
// [RULE_01] Supply lamp follows main supply presence
// [RULE_02] Field power lamp follows I/O supply
// [RULE_03] System green steady while online with master
// [RULE_04] System red steady on unrecovered fault
// [RULE_05] Diagnostic green steady while transfers run
// [RULE_06] Diagnostic red steady when module bus fails
// [RULE_07] Link green off at init, flash pending
// [RULE_08] Link green steady when connection established
// [RULE_09] Link red off when unpowered, offline, untested; code still flashes it on connect timeout without network power
// [RULE_10] Link red flashes on timeouts
// [RULE_11] Link red steady on serious faults
// [RULE_12] Distinct flash codes for waiting, swap, module faults
// [RULE_13] Flash timing from parameterised clock counters
`timescale 1ns/1ps
module csid_lamp_driver (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Supplies
    input wire logic main_supply_ok_i,
    input wire logic io_supply_ok_i,
    // Coupler operation
    input wire logic online_i,
    input wire logic master_active_i,
    input wire logic init_done_i,
    input wire logic init_fail_i,
    input wire logic run_fail_i,
    input wire logic fw_mismatch_i,
    input wire logic initializing_i,
    input wire logic netinit_fail_i,
    // Internal module bus
    input wire logic multi_xfer_run_i,
    input wire logic single_xfer_run_i,
    input wire logic internal_module_bus_fail_i,
    input wire logic hot_swap_i,
    input wire logic module_substituted_i,
    input wire logic no_module_i,
    input wire logic abnormal_module_i,
    input wire logic limit_exceeded_i,
    // Field network
    input wire logic link_init_i,
    input wire logic link_online_i,
    input wire logic link_connected_i,
    input wire logic link_conn_error_i,
    input wire logic net_power_ok_i,
    input wire logic addr_test_done_i,
    input wire logic exchange_timeout_i,
    input wire logic connect_timeout_i,
    input wire logic serious_fault_i,
    input wire logic dup_address_i,
    // Lamps
    output logic supply_lamp_o,
    output logic io_power_lamp_o,
    output logic system_lamp_green_o,
    output logic system_lamp_red_o,
    output logic module_health_lamp_green_o,
    output logic module_health_lamp_red_o,
    output logic fieldbus_link_lamp_green_o,
    output logic fieldbus_link_lamp_red_o
);
    typedef struct packed {
        logic supply;
        logic io_power;
        logic sys_g;
        logic sys_r;
        logic module_health_lamp_g;
        logic module_health_lamp_r;
        logic link_g;
        logic link_r;
    } csid_lamp_state_t;

    csid_lamp_state_t st;
    csid_lamp_state_t next_st;
    csid_flash_if flash_bus ();

    csid_flash_gen u_flash (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .flash(flash_bus.gen)
    );

    // Map a display pattern to the lamp level at this moment
    function automatic logic pattern_level(input csid_pkg::csid_pattern_t pat, input logic plain,
                                           input logic [2:0] burst);
        unique case (pat)
            csid_pkg::CSID_OFF: pattern_level = 1'b0;
            csid_pkg::CSID_ON: pattern_level = 1'b1;
            csid_pkg::CSID_FLASH: pattern_level = plain;
            csid_pkg::CSID_FLASH_2: pattern_level = burst[0];
            csid_pkg::CSID_FLASH_3: pattern_level = burst[1];
            csid_pkg::CSID_FLASH_4: pattern_level = burst[2];
            default: pattern_level = 1'b0;
        endcase
    endfunction

    // Pattern that leaves its element dark
    function automatic logic is_dark(input csid_pkg::csid_pattern_t pat);
        is_dark = (pat == csid_pkg::CSID_OFF);
    endfunction

    // Link may report only with supply and node online
    function automatic logic link_reachable(input logic supply_ok, input logic online);
        link_reachable = supply_ok && online;
    endfunction

    csid_pkg::csid_pattern_t sys_g_pat;
    csid_pkg::csid_pattern_t sys_r_pat;
    csid_pkg::csid_pattern_t module_health_lamp_g_pat;
    csid_pkg::csid_pattern_t module_health_lamp_r_pat;
    csid_pkg::csid_pattern_t link_g_pat;
    csid_pkg::csid_pattern_t link_r_pat;

    always_comb begin
        // System lamp
        sys_r_pat = csid_pkg::CSID_OFF;
        if (init_fail_i || run_fail_i || fw_mismatch_i) begin
            sys_r_pat = csid_pkg::CSID_ON; // [RULE_04]
        end else if (initializing_i || netinit_fail_i) begin
            sys_r_pat = csid_pkg::CSID_FLASH; // [RULE_12]
        end
        sys_g_pat = csid_pkg::CSID_OFF;
        // Green only while red is dark
        if (is_dark(sys_r_pat)) begin
            if (online_i && master_active_i) begin
                sys_g_pat = csid_pkg::CSID_ON; // [RULE_03]
            end else if (init_done_i) begin
                sys_g_pat = csid_pkg::CSID_FLASH; // [RULE_12]
            end
        end

        // Module health lamp
        module_health_lamp_r_pat = csid_pkg::CSID_OFF;
        // Steady bus fault outranks every flash code
        if (internal_module_bus_fail_i) begin
            module_health_lamp_r_pat = csid_pkg::CSID_ON; // [RULE_06]
        end else if (limit_exceeded_i) begin
            module_health_lamp_r_pat = csid_pkg::CSID_FLASH_4; // [RULE_12]
        end else if (abnormal_module_i) begin
            module_health_lamp_r_pat = csid_pkg::CSID_FLASH_3; // [RULE_12]
        end else if (no_module_i) begin
            module_health_lamp_r_pat = csid_pkg::CSID_FLASH_2; // [RULE_12]
        end else if (module_substituted_i) begin
            module_health_lamp_r_pat = csid_pkg::CSID_FLASH; // [RULE_12]
        end
        module_health_lamp_g_pat = csid_pkg::CSID_OFF;
        if (is_dark(module_health_lamp_r_pat)
                || (module_substituted_i && module_health_lamp_r_pat == csid_pkg::CSID_FLASH)) begin
            if (hot_swap_i) begin
                module_health_lamp_g_pat = csid_pkg::CSID_FLASH; // [RULE_12]
            end else if (multi_xfer_run_i && single_xfer_run_i && is_dark(module_health_lamp_r_pat)) begin
                module_health_lamp_g_pat = csid_pkg::CSID_ON; // [RULE_05]
            end
        end

        // Field network link lamp
        link_r_pat = csid_pkg::CSID_OFF;
        if (link_reachable(main_supply_ok_i, link_online_i) && net_power_ok_i && addr_test_done_i) begin // [RULE_09]
            if (serious_fault_i || dup_address_i) begin
                link_r_pat = csid_pkg::CSID_ON; // [RULE_11]
            end else if (exchange_timeout_i || connect_timeout_i) begin
                link_r_pat = csid_pkg::CSID_FLASH; // [RULE_10]
            end
        end else if (link_reachable(main_supply_ok_i, link_online_i) && !net_power_ok_i
                && connect_timeout_i) begin
            // Connection timeout still flashes when network power is missing
            link_r_pat = csid_pkg::CSID_FLASH; // [RULE_10]
        end
        link_g_pat = csid_pkg::CSID_OFF;
        if (!link_init_i && link_online_i) begin // [RULE_07]
            if (link_connected_i && !link_conn_error_i) begin
                link_g_pat = csid_pkg::CSID_ON; // [RULE_08]
            end else begin
                link_g_pat = csid_pkg::CSID_FLASH; // [RULE_07]
            end
        end
    end

    // Element order: system, health, link; green before red
    csid_pkg::csid_pattern_t elem_pat [6];
    logic [5:0] elem_level;

    assign elem_pat[0] = sys_g_pat;
    assign elem_pat[1] = sys_r_pat;
    assign elem_pat[2] = module_health_lamp_g_pat;
    assign elem_pat[3] = module_health_lamp_r_pat;
    assign elem_pat[4] = link_g_pat;
    assign elem_pat[5] = link_r_pat;

    for (genvar k = 0; k < 6; k++) begin : g_level
        assign elem_level[k] = pattern_level(elem_pat[k], flash_bus.plain, flash_bus.burst); // [RULE_13]
    end

    always_comb begin
        next_st.supply = main_supply_ok_i; // [RULE_01]
        next_st.io_power = io_supply_ok_i; // [RULE_02]
        next_st.sys_g = elem_level[0];
        next_st.sys_r = elem_level[1];
        next_st.module_health_lamp_g = elem_level[2];
        next_st.module_health_lamp_r = elem_level[3];
        next_st.link_g = elem_level[4];
        next_st.link_r = elem_level[5];
    end

    // Lamps registered so every output leaves a flip-flop
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign supply_lamp_o = st.supply;
    assign io_power_lamp_o = st.io_power;
    assign system_lamp_green_o = st.sys_g;
    assign system_lamp_red_o = st.sys_r;
    assign module_health_lamp_green_o = st.module_health_lamp_g;
    assign module_health_lamp_red_o = st.module_health_lamp_r;
    assign fieldbus_link_lamp_green_o = st.link_g;
    assign fieldbus_link_lamp_red_o = st.link_r;
endmodule

// file: verilog/csid_pkg.sv
// Purpose: Constants and types shared by the status lamp driver
// Assumes: 25 MHz reference clock
// Notes: Flash timing is a free choice, kept here as named values
package csid_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned FLASH_HALF_MS = 200;
    localparam int unsigned BURST_GAP_MS = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam int unsigned GAP_TICKS = BURST_GAP_MS / FLASH_HALF_MS;
    localparam int unsigned TICK_W = 24;
    localparam int unsigned PHASE_W = 5;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [TICK_W-1:0] TICK_RST = 24'h00_0000;
    localparam logic [PHASE_W-1:0] PHASE_RST = 5'h00;
    // Burst codes: n pulses then a gap
    localparam int unsigned BURST_MAX = 4;
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(2 * BURST_MAX + GAP_TICKS - 1);

    typedef enum logic [2:0] {
        CSID_OFF = 3'b000,
        CSID_ON = 3'b001,
        CSID_FLASH = 3'b010,
        CSID_FLASH_2 = 3'b011,
        CSID_FLASH_3 = 3'b100,
        CSID_FLASH_4 = 3'b101
    } csid_pattern_t;
endpackage

// file: verilog/csid_flash_if.sv
// Purpose: Flash waveforms from the generator to the lamp logic
// Assumes: One clock domain
// Notes: All waves are levels
`timescale 1ns/1ps
interface csid_flash_if;
    logic plain;
    logic [2:0] burst;
    modport gen (output plain, output burst);
    modport use_side (input plain, input burst);
endinterface

// file: verilog/csid_flash_gen.sv
// Purpose: Free-running flash waveform generator
// Assumes: Synchronous inputs, asynchronous active-low reset
// Notes: burst[k] gives k+2 pulses then a gap
`timescale 1ns/1ps
module csid_flash_gen (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Waveforms
    csid_flash_if.gen flash
);
    typedef struct packed {
        logic [csid_pkg::TICK_W-1:0] tick;
        logic [csid_pkg::PHASE_W-1:0] phase;
        logic plain;
        logic [2:0] burst;
    } csid_gen_state_t;

    csid_gen_state_t st;
    csid_gen_state_t next_st;

    always_comb begin
        next_st = st;
        if (st.tick == csid_pkg::TICK_LAST) begin // [RULE_13]
            next_st.tick = csid_pkg::TICK_RST;
            next_st.plain = ~st.plain;
            next_st.phase = (st.phase == csid_pkg::PHASE_LAST) ? csid_pkg::PHASE_RST
                : st.phase + 5'h01;
        end else begin
            next_st.tick = st.tick + 24'h00_0001;
        end
        for (int k = 0; k < 3; k++) begin
            // Even phases below 2*(k+2) are lit
            next_st.burst[k] = (next_st.phase < 5'(2 * (k + 2))) && !next_st.phase[0]; // [RULE_13]
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flash.plain = st.plain;
    assign flash.burst = st.burst;
endmodule

// file: tb/csid_lamp_monitor.sv
// Purpose: Port assertions for the status lamp driver
// Assumes: One clock, lamps registered one cycle after the inputs
// Notes: Flash states are not asserted, only steady and dark ones
`timescale 1ns/1ps
module csid_lamp_monitor (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Status inputs
    input wire logic main_supply_ok_i,
    input wire logic io_supply_ok_i,
    input wire logic init_fail_i,
    input wire logic run_fail_i,
    input wire logic fw_mismatch_i,
    input wire logic internal_module_bus_fail_i,
    input wire logic link_init_i,
    input wire logic link_online_i,
    input wire logic link_connected_i,
    input wire logic link_conn_error_i,
    input wire logic net_power_ok_i,
    input wire logic addr_test_done_i,
    input wire logic serious_fault_i,
    input wire logic dup_address_i,
    // Lamps
    input wire logic supply_lamp_o,
    input wire logic io_power_lamp_o,
    input wire logic system_lamp_green_o,
    input wire logic system_lamp_red_o,
    input wire logic module_health_lamp_green_o,
    input wire logic module_health_lamp_red_o,
    input wire logic fieldbus_link_lamp_green_o,
    input wire logic fieldbus_link_lamp_red_o
);
    logic armed;

    // Checks off until one edge after any reset release
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i || !armed);
    sequence s_sys_fault;
        init_fail_i || run_fail_i || fw_mismatch_i;
    endsequence
    sequence s_linked;
        link_online_i && link_connected_i && !link_conn_error_i && !link_init_i;
    endsequence
    sequence s_serious;
        main_supply_ok_i && link_online_i && net_power_ok_i && addr_test_done_i && (serious_fault_i || dup_address_i);
    endsequence
    property p_supply; 1'b1 |=> supply_lamp_o == $past(main_supply_ok_i); endproperty
    property p_io; 1'b1 |-> ##1 io_power_lamp_o == $past(io_supply_ok_i); endproperty
    property p_sys_red; s_sys_fault |=> system_lamp_red_o; endproperty
    property p_sys_green; s_sys_fault |=> !system_lamp_green_o; endproperty
    property p_hl_red; internal_module_bus_fail_i |=> module_health_lamp_red_o; endproperty
    property p_hl_green; internal_module_bus_fail_i |-> ##1 !module_health_lamp_green_o; endproperty
    property p_ln_green_off; link_init_i |=> !fieldbus_link_lamp_green_o; endproperty
    property p_ln_green_on; s_linked |=> fieldbus_link_lamp_green_o; endproperty
    property p_ln_red_off; net_power_ok_i && !addr_test_done_i |=> !fieldbus_link_lamp_red_o; endproperty
    property p_ln_red_on; s_serious |=> fieldbus_link_lamp_red_o; endproperty
    a_supply: assert property (p_supply) else $error("supply lamp wrong");
    a_io: assert property (p_io) else $error("io power lamp wrong");
    a_sys_red: assert property (p_sys_red) else $error("system red not lit");
    a_sys_green: assert property (p_sys_green) else $error("system green lit on fault");
    a_hl_red: assert property (p_hl_red) else $error("health red not lit");
    a_hl_green: assert property (p_hl_green) else $error("health green lit on bus fault");
    a_ln_green_off: assert property (p_ln_green_off) else $error("link green lit in init");
    a_ln_green_on: assert property (p_ln_green_on) else $error("link green not steady");
    a_ln_red_off: assert property (p_ln_red_off) else $error("link red lit untested");
    a_ln_red_on: assert property (p_ln_red_on) else $error("link red not steady");
endmodule
bind csid_lamp_driver csid_lamp_monitor u_mon (.*);

// file: tb/csid_lamp_viewer.sv
// Purpose: Operator view of the front-panel lamps
// Assumes: Lamps active high
// Notes: Passive, reports what is lit
`timescale 1ns/1ps
module csid_lamp_viewer (
    // Lamps
    input wire logic [7:0] lamp_i,
    // View
    output logic [7:0] seen_o
);
    assign seen_o = lamp_i;
endmodule

// file: tb/coupler_status_indicator_driver_tb_top.sv
// Purpose: Self-checking bench for the status lamp driver
// Assumes: Run ends long before the first flash toggle
// Notes: Plain flash reads dark, burst codes lit in their first phase
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
    $display("mismatch %s expected %b seen %b", nm, ex, got); end end
module coupler_status_indicator_driver_tb_top;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [26:0] st = 27'h000_0000;
    logic [7:0] lamp;
    logic [7:0] seen;
    int errors = 0;
    int check_count = 0;
    logic [23:0] corner [6] = '{24'h00_0000, 24'h0D_018F, 24'h4D_018F, 24'h0D_418F, 24'h0D_038F, 24'h45_018F};
    always #20 ref_clk_i = ~ref_clk_i;
    csid_lamp_driver uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .main_supply_ok_i(st[0]),
        .io_supply_ok_i(st[1]), .online_i(st[2]), .master_active_i(st[3]), .init_done_i(st[24]),
        .init_fail_i(st[4]), .run_fail_i(st[5]), .fw_mismatch_i(st[6]), .initializing_i(st[25]),
        .netinit_fail_i(st[26]), .multi_xfer_run_i(st[7]), .single_xfer_run_i(st[8]),
        .internal_module_bus_fail_i(st[9]), .hot_swap_i(st[10]), .module_substituted_i(st[11]),
        .no_module_i(st[12]), .abnormal_module_i(st[13]), .limit_exceeded_i(st[14]), .link_init_i(st[15]),
        .link_online_i(st[2]), .link_connected_i(st[16]), .link_conn_error_i(st[17]), .net_power_ok_i(st[18]),
        .addr_test_done_i(st[19]), .exchange_timeout_i(st[20]), .connect_timeout_i(st[21]),
        .serious_fault_i(st[22]), .dup_address_i(st[23]), .supply_lamp_o(lamp[7]), .io_power_lamp_o(lamp[6]),
        .system_lamp_green_o(lamp[5]), .system_lamp_red_o(lamp[4]), .module_health_lamp_green_o(lamp[3]),
        .module_health_lamp_red_o(lamp[2]), .fieldbus_link_lamp_green_o(lamp[1]),
        .fieldbus_link_lamp_red_o(lamp[0]));
    csid_lamp_viewer u_view (.lamp_i(lamp), .seen_o(seen));
    function automatic logic [7:0] expect_lamps(input logic [26:0] s);
        logic sr;
        logic sf;
        logic hr;
        sr = s[4] | s[5] | s[6];
        sf = s[25] | s[26];
        hr = s[9] | s[12] | s[13] | s[14];
        return {s[0], s[1], s[2] & s[3] & ~sr & ~sf, sr, s[7] & s[8] & ~s[10] & ~s[11] & ~hr, hr,
            ~s[15] & s[2] & s[16] & ~s[17], s[0] & s[2] & s[18] & s[19] & (s[22] | s[23])};
    endfunction
    task automatic apply(input logic [26:0] v);
        logic [7:0] e;
        @(posedge ref_clk_i) st <= v;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        e = expect_lamps(v);
        `CHK("supply", e[7], seen[7])
        `CHK("io_power", e[6], seen[6])
        `CHK("system_green", e[5], seen[5])
        `CHK("system_red", e[4], seen[4])
        `CHK("health_green", e[3], seen[3])
        `CHK("health_red", e[2], seen[2])
        `CHK("link_green", e[1], seen[1])
        `CHK("link_red", e[0], seen[0])
    endtask
    task automatic test_done();
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h3198));
        repeat (12) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        foreach (corner[i]) begin
            apply(27'(corner[i]));
        end
        // Mid-run reset with lamps lit
        @(posedge ref_clk_i) arst_n_i <= 1'b0;
        @(negedge ref_clk_i);
        `CHK("reset_lamps", 8'h00, seen)
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        repeat (400) apply(27'($urandom()));
        test_done();
    end
    initial begin
        #(40 * 10000);
        errors++;
        test_done();
    end
endmodule
